// file: rtl/lbms_mode_sequencer.sv
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
// How it works
// - in lockout both half-bridge gates stay low and the timing ramp and preheat timer nodes are held discharged.
// - lockout is left only when supply is at start-up level, bus sense is not low and shutdown is below its 5.0 V level.
// - the first gate pulse after lockout goes to the low side so the bootstrap charges first.
// - in preheat the two gates alternate at equal on-times with dead time between them.
// - each rising ramp phase from 1/3 to 3/5 of supply is the on-time of the gate whose turn it is.
// - each falling ramp phase holds both gates low, then the other gate takes its turn.
// - on entering preheat the preheat timer is released and preheat lasts until it passes 10 V, then ignition.
// - each current-sense excursion above 1.3 V during a low-side on-time in ignition, or in preheat while protection is on, advances the over-current counter.
// - a count beyond 25 enters fault and latches the high, low and boost gates low.
// - in fault, from shutdown above 5.0 V or current above 1.3 V, frequency and timing nodes are grounded.
// - the lifetime window on shutdown is checked only once the preheat timer passes about 12 V.
// - bus sense below 3.0 V shuts the device down.
// - in run a single current excursion faults; in preheat and ignition only low-side on-time events count.
// - in run the lifetime input above about 3 V or below about 1 V enters fault.
// - fault is left only by supply dropping out, bus sense going low or shutdown above 5.2 V, all returning to lockout.
module lbms_mode_sequencer
  import lbms_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // comparator flags
  input wire lbms_cmp_t cmpIn,
  // gate drives and node controls
  output lbms_drive_t driveOut,
  // interrupt
  output logic irq,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // word match on an aligned address
  function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
    regHit = (addr[ADDR_W-1:2] == offset[ADDR_W-1:2]);
  endfunction

  lbms_cmp_t c;
  lbms_mode_t mode_ff, nxt_mode;
  logic phaseCharge_ff, nxt_phaseCharge, turnLow_ff, nxt_turnLow, seenInCycle_ff, nxt_seenInCycle, currentOverDly_ff;
  logic [OC_COUNT_W-1:0] ocCount_ff, nxt_ocCount;
  lbms_drive_t drive_ff, nxt_drive;
  logic ocpWarmEn_ff, nxt_ocpWarmEn, awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld, bvalid_ff, nxt_bvalid;
  logic [IRQ_W-1:0] irqStatus_ff, nxt_irqStatus, irqEnable_ff, nxt_irqEnable, irqEvents, irqClear;
  logic [ADDR_W-1:0] awAddr_ff, nxt_awAddr;
  logic [31:0] wData_ff, nxt_wData, rdata_ff, nxt_rdata;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic oscActive, nxtOscActive, currentRise, lowOnTime, ocEvent, ocTrip, cycleEnd;
  logic rvalid_ff, nxt_rvalid, faultCond, doWrite;

  // comparator flags through two flops
  lbms_sync #(.W(CMP_W)) u_sync (
    .clock(clock),
    .reset(reset),
    .asyncIn(cmpIn),
    .syncOut(c)
  );

  // protection terms
  always_comb begin
    oscActive = (mode_ff == MODE_WARM) || (mode_ff == MODE_STRIKE) || (mode_ff == MODE_RUN);
    currentRise = c.currentOver && !currentOverDly_ff;
    lowOnTime = phaseCharge_ff && turnLow_ff && !c.rampLower;
    ocEvent = currentRise && lowOnTime && ((mode_ff == MODE_STRIKE) ||
              ((mode_ff == MODE_WARM) && ocpWarmEn_ff));
    ocTrip = ocEvent && (ocCount_ff == OC_FAULT_LIMIT);
    cycleEnd = !phaseCharge_ff && c.rampLower && !turnLow_ff;
    faultCond = c.shutdownHigh || ocTrip;
    if (mode_ff == MODE_RUN) begin
      faultCond = faultCond || c.currentOver;
      faultCond = faultCond || (c.lifetimeEnable && (c.lifetimeHigh || c.lifetimeLow));
    end
  end

  // mode transitions
  always_comb begin
    nxt_mode = mode_ff;
    if (!c.supplyOk || c.busLow) begin
      nxt_mode = MODE_LOCKOUT;
    end else begin
      unique case (mode_ff)
        MODE_LOCKOUT: begin
          if (!c.shutdownHigh) begin
            nxt_mode = MODE_WARM;
          end
        end
        MODE_WARM: begin
          if (faultCond) begin
            nxt_mode = MODE_FAULT;
          end else if (c.preheatDone) begin
            nxt_mode = MODE_STRIKE;
          end
        end
        MODE_STRIKE: begin
          if (faultCond) begin
            nxt_mode = MODE_FAULT;
          end else if (c.lifetimeEnable) begin
            nxt_mode = MODE_RUN;
          end
        end
        MODE_RUN: begin
          if (faultCond) begin
            nxt_mode = MODE_FAULT;
          end
        end
        MODE_FAULT: begin
          if (c.shutdownReset) begin
            nxt_mode = MODE_LOCKOUT;
          end
        end
      endcase
    end
  end

  // ramp phase and gate turn
  always_comb begin
    nxtOscActive = (nxt_mode == MODE_WARM) || (nxt_mode == MODE_STRIKE) || (nxt_mode == MODE_RUN);
    nxt_phaseCharge = phaseCharge_ff;
    nxt_turnLow = turnLow_ff;
    if (!oscActive || !nxtOscActive) begin
      nxt_phaseCharge = 1'b1;
      nxt_turnLow = 1'b1;
    end else if (phaseCharge_ff && c.rampUpper) begin
      nxt_phaseCharge = 1'b0;
    end else if (!phaseCharge_ff && c.rampLower) begin
      nxt_phaseCharge = 1'b1;
      nxt_turnLow = !turnLow_ff;
    end
  end

  // sequential over-current counter
  always_comb begin
    nxt_ocCount = ocCount_ff;
    nxt_seenInCycle = seenInCycle_ff || ocEvent;
    if (mode_ff == MODE_LOCKOUT) begin
      nxt_ocCount = '0;
      nxt_seenInCycle = 1'b0;
    end else begin
      if (cycleEnd) begin
        nxt_seenInCycle = ocEvent;
        if (!seenInCycle_ff) begin
          nxt_ocCount = '0;
        end
      end
      if (ocEvent && (ocCount_ff != '1)) begin
        nxt_ocCount = nxt_ocCount + 1'b1;
      end
    end
  end

  // gate drives follow next state
  always_comb begin
    nxt_drive = DRIVE_RESET;
    if (nxtOscActive) begin
      nxt_drive.highSideGateOut = nxt_phaseCharge && !nxt_turnLow && !c.rampLower;
      nxt_drive.lowSideGateOut = nxt_phaseCharge && nxt_turnLow && !c.rampLower;
      nxt_drive.boostGateOut = 1'b1;
      nxt_drive.timingRampCharge = nxt_phaseCharge;
      nxt_drive.timingRampDischarge = !nxt_phaseCharge;
      nxt_drive.preheatTimerDischarge = 1'b0;
    end
    nxt_drive.freqNodeHold = (nxt_mode == MODE_FAULT);
  end

  // sequencer state
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_ff <= MODE_LOCKOUT;
      phaseCharge_ff <= 1'b1;
      turnLow_ff <= 1'b1;
      ocCount_ff <= '0;
      seenInCycle_ff <= 1'b0;
      currentOverDly_ff <= 1'b0;
      drive_ff <= DRIVE_RESET;
    end else begin
      mode_ff <= nxt_mode;
      phaseCharge_ff <= nxt_phaseCharge;
      turnLow_ff <= nxt_turnLow;
      ocCount_ff <= nxt_ocCount;
      seenInCycle_ff <= nxt_seenInCycle;
      currentOverDly_ff <= c.currentOver;
      drive_ff <= nxt_drive;
    end
  end
  assign driveOut = drive_ff;
  // interrupt events and sticky status, set wins over clear
  always_comb begin
    irqEvents = '0;
    irqEvents[IRQ_FAULT] = (nxt_mode == MODE_FAULT) && (mode_ff != MODE_FAULT);
    irqEvents[IRQ_STRIKE] = (nxt_mode == MODE_STRIKE) && (mode_ff != MODE_STRIKE);
    irqEvents[IRQ_RUN] = (nxt_mode == MODE_RUN) && (mode_ff != MODE_RUN);
    irqEvents[IRQ_BUS_UV] = c.busLow && (mode_ff != MODE_LOCKOUT);
    irqEvents[IRQ_OC_EVENT] = ocEvent;
    irqClear = '0;
    if (doWrite && regHit(awAddr_ff, ADDR_IRQ_CLEAR) && wStrb_ff[0]) begin
      irqClear = wData_ff[IRQ_W-1:0];
    end
    nxt_irqStatus = (irqStatus_ff & ~irqClear) | irqEvents;
  end

  assign irq = |(irqStatus_ff & irqEnable_ff);
  // write channel: hold address and data, answer once both are in
  always_comb begin
    doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
    s_axi_awready = !awHeld_ff && !bvalid_ff;
    s_axi_wready = !wHeld_ff && !bvalid_ff;
    nxt_awHeld = awHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wHeld = wHeld_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_ocpWarmEn = ocpWarmEn_ff;
    nxt_irqEnable = irqEnable_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_wHeld = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      if (regHit(awAddr_ff, ADDR_CTRL)) begin
        if (wStrb_ff[0]) begin
          nxt_ocpWarmEn = wData_ff[CTRL_OCP_WARM_BIT];
        end
      end else if (regHit(awAddr_ff, ADDR_IRQ_ENABLE)) begin
        if (wStrb_ff[0]) begin
          nxt_irqEnable = wData_ff[IRQ_W-1:0];
        end
      end else if (!regHit(awAddr_ff, ADDR_STATUS) && !regHit(awAddr_ff, ADDR_IRQ_STATUS) &&
                   !regHit(awAddr_ff, ADDR_IRQ_CLEAR)) begin
        nxt_bresp = RESP_SLVERR;
      end
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // read channel: one registered answer per address
  always_comb begin
    s_axi_arready = !rvalid_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = '0;
      nxt_rresp = RESP_OKAY;
      if (regHit(s_axi_araddr, ADDR_CTRL)) begin
        nxt_rdata[CTRL_OCP_WARM_BIT] = ocpWarmEn_ff;
      end else if (regHit(s_axi_araddr, ADDR_STATUS)) begin
        nxt_rdata[ST_MODE_LSB +: 3] = mode_ff;
        nxt_rdata[ST_TURN_BIT] = turnLow_ff;
        nxt_rdata[ST_PHASE_BIT] = phaseCharge_ff;
        nxt_rdata[ST_COUNT_LSB +: OC_COUNT_W] = ocCount_ff;
      end else if (regHit(s_axi_araddr, ADDR_IRQ_STATUS)) begin
        nxt_rdata[IRQ_W-1:0] = irqStatus_ff;
      end else if (regHit(s_axi_araddr, ADDR_IRQ_ENABLE)) begin
        nxt_rdata[IRQ_W-1:0] = irqEnable_ff;
      end else if (!regHit(s_axi_araddr, ADDR_IRQ_CLEAR)) begin
        nxt_rresp = RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // register file and bus state
  always_ff @(posedge clock) begin
    if (reset) begin
      ocpWarmEn_ff <= CTRL_OCP_WARM_RESET;
      irqStatus_ff <= IRQ_RESET;
      irqEnable_ff <= IRQ_RESET;
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff <= 1'b0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      ocpWarmEn_ff <= nxt_ocpWarmEn;
      irqStatus_ff <= nxt_irqStatus;
      irqEnable_ff <= nxt_irqEnable;
      awHeld_ff <= nxt_awHeld;
      awAddr_ff <= nxt_awAddr;
      wHeld_ff <= nxt_wHeld;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

// file: rtl/lbms_pkg.sv
package lbms_pkg;

  // register byte offsets
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h10;

  // control register fields
  localparam int CTRL_OCP_WARM_BIT = 0;
  localparam logic CTRL_OCP_WARM_RESET = 1'b1;

  // status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_TURN_BIT = 4;
  localparam int ST_PHASE_BIT = 5;
  localparam int ST_COUNT_LSB = 8;

  // over-current counter
  localparam int OC_COUNT_W = 5;
  localparam logic [4:0] OC_FAULT_LIMIT = 5'h19;

  // interrupt bits
  localparam int IRQ_W = 5;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_STRIKE = 1;
  localparam int IRQ_RUN = 2;
  localparam int IRQ_BUS_UV = 3;
  localparam int IRQ_OC_EVENT = 4;
  localparam logic [4:0] IRQ_RESET = 5'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_LOCKOUT,
    MODE_WARM,
    MODE_STRIKE,
    MODE_RUN,
    MODE_FAULT
  } lbms_mode_t;

  // comparator flags, all active high
  typedef struct packed {
    logic supplyOk;
    logic shutdownHigh;
    logic shutdownReset;
    logic lifetimeHigh;
    logic lifetimeLow;
    logic currentOver;
    logic busLow;
    logic rampUpper;
    logic rampLower;
    logic preheatDone;
    logic lifetimeEnable;
  } lbms_cmp_t;

  // gate drives and node controls
  typedef struct packed {
    logic highSideGateOut;
    logic lowSideGateOut;
    logic boostGateOut;
    logic timingRampCharge;
    logic timingRampDischarge;
    logic preheatTimerDischarge;
    logic freqNodeHold;
  } lbms_drive_t;

  localparam int CMP_W = $bits(lbms_cmp_t);
  localparam lbms_drive_t DRIVE_RESET = '{default: 1'b0, timingRampDischarge: 1'b1, preheatTimerDischarge: 1'b1};

endpackage

// file: rtl/lbms_sync.sv
`timescale 1ns/10ps
module lbms_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // flags
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // two-flop synchroniser, first stage read only by second
  always_ff @(posedge clock) begin
    if (reset) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;

endmodule

// file: testbench/lbms_mode_sequencer_properties.sv
`timescale 1ns/10ps
module lbms_checker
  import lbms_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // pins
  input wire lbms_cmp_t cmpIn,
  input wire lbms_drive_t driveOut,
  // bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  logic hs;
  logic ls;
  logic pd;
  logic wantHigh_ff;
  logic nxt_wantHigh;
  assign hs = driveOut.highSideGateOut;
  assign ls = driveOut.lowSideGateOut;
  assign pd = driveOut.preheatTimerDischarge;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // side owed the next pulse, low first after a stop
  always_comb begin
    nxt_wantHigh = wantHigh_ff;
    if (pd) begin
      nxt_wantHigh = 1'h0;
    end else if (ls) begin
      nxt_wantHigh = 1'h1;
    end else if (hs) begin
      nxt_wantHigh = 1'h0;
    end
  end
  always_ff @(posedge clock) begin
    wantHigh_ff <= reset ? 1'h0 : nxt_wantHigh;
  end
  a_gate_overlap: assert property (!(hs && ls))
    else $error("both gates on");
  a_first_low: assert property ($rose(hs) |-> wantHigh_ff)
    else $error("high side out of turn");
  a_gate_alternate: assert property ($rose(ls) |-> !wantHigh_ff)
    else $error("low side out of turn");
  a_on_charge: assert property ((hs || ls) |-> driveOut.timingRampCharge && !driveOut.timingRampDischarge)
    else $error("gate on outside charge");
  a_dead_low: assert property (driveOut.timingRampDischarge |-> !hs && !ls)
    else $error("gate on during discharge");
  a_fault_latch: assert property (driveOut.freqNodeHold |-> !hs && !ls && !driveOut.boostGateOut
    && driveOut.timingRampDischarge && pd)
    else $error("fault outputs wrong");
  a_lockout_gates: assert property (!cmpIn.supplyOk [*4] |=> !hs && !ls && pd)
    else $error("lockout not held");
  a_bus_uv: assert property (cmpIn.busLow [*4] |=> !hs && !ls && pd)
    else $error("bus low not stopped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
endmodule
bind lbms_mode_sequencer lbms_checker chk_u (
  .clock(clock),
  .reset(reset),
  .cmpIn(cmpIn),
  .driveOut(driveOut),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp)
);

// file: testbench/lbms_power_stage_model.sv
`timescale 1ns/10ps
module lbms_power_stage_model
  import lbms_pkg::*;
#(
  parameter int RAMP_TOP = 12,
  parameter int RAMP_LOW = 4,
  parameter int WARM_END = 4000,
  parameter int LIFE_ON = 6000
) (
  // clock
  input wire logic clock,
  // drives from the block
  input wire lbms_drive_t driveOut,
  // comparator flags back
  output logic rampUpper,
  output logic rampLower,
  output logic preheatDone,
  output logic lifetimeEnable
);
  int ramp = 0;
  int tmr = 0;
  // timing capacitor one step a cycle each way, preheat capacitor one step a cycle up and cleared at once
  always @(posedge clock) begin
    if (driveOut.timingRampDischarge) begin
      ramp <= (ramp > 0) ? ramp - 1 : 0;
    end else if (driveOut.timingRampCharge) begin
      ramp <= ramp + 1;
    end
    tmr <= driveOut.preheatTimerDischarge ? 0 : tmr + 1;
  end
  // threshold comparators
  assign rampUpper = ramp >= RAMP_TOP;
  assign rampLower = ramp <= RAMP_LOW;
  assign preheatDone = tmr > WARM_END;
  assign lifetimeEnable = tmr > LIFE_ON;
endmodule

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb
  import lbms_pkg::*;
;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic supOk = 1'h0;
  logic sdHi = 1'h0;
  logic sdRst = 1'h0;
  logic lifeHi = 1'h0;
  logic curOv = 1'h0;
  logic busLo = 1'h0;
  logic ocOn = 1'h0;
  logic lifeLo = 1'h0;
  logic lsD = 1'h0;
  logic rUp, rLo, phDone, lifeEn, irq;
  lbms_cmp_t cmpIn;
  lbms_drive_t drive;
  logic [4:0] awaddr = 5'h0;
  logic [4:0] araddr = 5'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0] bresp, rresp, r;
  int err_count = 0;
  int total_checks = 0;
  int ocEvents = 0;
  int i;
  int n0;
  assign cmpIn = '{supplyOk: supOk, shutdownHigh: sdHi, shutdownReset: sdRst, lifetimeHigh: lifeHi,
    lifetimeLow: lifeLo, currentOver: curOv, busLow: busLo, rampUpper: rUp, rampLower: rLo,
    preheatDone: phDone, lifetimeEnable: lifeEn};
  // clock
  always #10 clock = ~clock;
  // sense excursion over a whole low-side on-time, started only at the gate's rise
  always @(posedge clock) begin
    lsD <= drive.lowSideGateOut;
    curOv <= drive.lowSideGateOut && (curOv || (ocOn && !lsD));
    if (ocOn && drive.lowSideGateOut && !lsD) ocEvents <= ocEvents + 1;
  end
  lbms_mode_sequencer dut_u (.clock(clock), .reset(reset), .cmpIn(cmpIn), .driveOut(drive), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  lbms_power_stage_model ps_u (.clock(clock), .driveOut(drive), .rampUpper(rUp), .rampLower(rLo),
    .preheatDone(phDone), .lifetimeEnable(lifeEn));
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task hang;
    err_count++;
    $display("BAD wait exp done got timeout");
    end_of_test();
  endtask
  // bus write, both channels offered together
  task wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic ta;
    logic tw;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge clock);
      if (bvalid) break;
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clock);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    if (n == 50) hang();
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clock);
    bready <= 1'h0;
  endtask
  // bus read
  task rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ta;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge clock);
      if (rvalid) break;
      ta = arvalid && arready;
      @(posedge clock);
      if (ta) arvalid <= 1'h0;
    end
    if (n == 50) hang();
    v = rdata;
    rs = rresp;
    @(posedge clock);
    rready <= 1'h0;
  endtask
  task rchk(input string nm, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, d, r);
    chk(nm, e, d & m);
  endtask
  task wmode(input logic [2:0] m);
    int k;
    for (k = 0; k < 400; k++) begin
      rd(ADDR_STATUS, d, r);
      if (d[2:0] === m) break;
      repeat (20) @(posedge clock);
    end
    if (k == 400) hang();
    chk("mode", {29'h0, m}, {29'h0, d[2:0]});
  endtask
  task unfault;
    sdHi <= 1'h1;
    sdRst <= 1'h1;
    wmode(MODE_LOCKOUT);
    sdHi <= 1'h0;
    sdRst <= 1'h0;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'h0;
    rchk("ctrl", ADDR_CTRL, 32'h1, 32'h1);
    rchk("irqen", ADDR_IRQ_ENABLE, 32'h1f, 32'h0);
    rchk("status", ADDR_STATUS, 32'h1f07, 32'h0);
    rd(5'h14, d, r);
    chk("unmapped", 32'h2, {30'h0, r});
    supOk <= 1'h1;
    sdHi <= 1'h1;
    repeat (100) @(posedge clock);
    rchk("held", ADDR_STATUS, 32'h7, 32'h0);
    sdHi <= 1'h0;
    wmode(MODE_WARM);
    wr(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
    ocOn <= 1'h1;
    for (i = 0; i < 5000 && ocEvents < 20; i++) @(posedge clock);
    if (i == 5000) hang();
    ocOn <= 1'h0;
    repeat (200) @(posedge clock);
    rchk("count", ADDR_STATUS, 32'h1f00, 32'h0);
    ocOn <= 1'h1;
    wmode(MODE_FAULT);
    chk("events", 32'd46, ocEvents);
    chk("irq", 32'h1, {31'h0, irq});
    rchk("irqst", ADDR_IRQ_STATUS, 32'h11, 32'h11);
    ocOn <= 1'h0;
    repeat (100) @(posedge clock);
    rchk("latched", ADDR_STATUS, 32'h7, 32'h4);
    wr(ADDR_IRQ_CLEAR, 32'h1f, RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    unfault();
    wr(ADDR_IRQ_ENABLE, 32'h2, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    rchk("ctrloff", ADDR_CTRL, 32'h1, 32'h0);
    ocOn <= 1'h1;
    repeat (300) @(posedge clock);
    ocOn <= 1'h0;
    rchk("offcount", ADDR_STATUS, 32'h1f00, 32'h0);
    rchk("offirq", ADDR_IRQ_STATUS, 32'h10, 32'h0);
    wmode(MODE_STRIKE);
    chk("irq", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_ENABLE, 32'h0, RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    wmode(MODE_RUN);
    rchk("runirq", ADDR_IRQ_STATUS, 32'h4, 32'h4);
    lifeHi <= 1'h1;
    wmode(MODE_FAULT);
    lifeHi <= 1'h0;
    supOk <= 1'h0;
    wmode(MODE_LOCKOUT);
    supOk <= 1'h1;
    wmode(MODE_RUN);
    n0 = ocEvents;
    ocOn <= 1'h1;
    wmode(MODE_FAULT);
    chk("runevents", n0 + 1, ocEvents);
    ocOn <= 1'h0;
    unfault();
    wmode(MODE_WARM);
    busLo <= 1'h1;
    wmode(MODE_LOCKOUT);
    rchk("uvflag", ADDR_IRQ_STATUS, 32'h8, 32'h8);
    busLo <= 1'h0;
    wmode(MODE_WARM);
    sdHi <= 1'h1;
    wmode(MODE_FAULT);
    sdHi <= 1'h0;
    supOk <= 1'h0;
    wmode(MODE_LOCKOUT);
    supOk <= 1'h1;
    wmode(MODE_RUN);
    lifeLo <= 1'h1;
    wmode(MODE_FAULT);
    lifeLo <= 1'h0;
    wr(5'h18, 32'h0, RESP_SLVERR);
    end_of_test();
  end
endmodule
